// [inc/ssphp_pkg.sv]
// Shared constants and types for the serial port and pulse output block
package ssphp_pkg;

    // ==========================================================
    // Frame layout
    localparam int          FRAME_HALF   = 16;           // Bits in address or data half
    localparam int          DIR_BIT      = 15;           // Direction bit of address word
    localparam logic [3:0]  LAST_BIT     = 4'hF;         // Count of last bit in a half

    // ==========================================================
    // Register offsets (low 15 bits of the address word)
    localparam logic [14:0] ADDR_PWM_CFG = 15'h000D;     // pwm_output_config
    localparam logic [14:0] ADDR_MAIN    = 15'h0100;     // Main output register
    localparam logic [14:0] ADDR_CHKSUM  = 15'h0108;     // read_checksum
    localparam logic [14:0] ADDR_LIN     = 15'h0122;     // Linear position register

    // ==========================================================
    // Config register field positions
    localparam int          CFG_HI_MSB   = 15;           // duty_upper_clamp top bit
    localparam int          CFG_HI_LSB   = 10;           // duty_upper_clamp low bit
    localparam int          CFG_LO_MSB   = 9;            // duty_lower_clamp top bit
    localparam int          CFG_LO_LSB   = 4;            // duty_lower_clamp low bit
    localparam int          CFG_EN_BIT   = 3;            // pulse_out_enable
    localparam int          CFG_SH_MSB   = 2;            // pulse_resolution_shift top bit

    // ==========================================================
    // Values after reset
    localparam logic [15:0] CFG_RST      = 16'h0000;     // Config reset value
    localparam logic [15:0] CHK_RST      = 16'h0000;     // Checksum start value
    localparam logic [15:0] WORD_RST     = 16'h0000;     // Other data words

    // ==========================================================
    // Pulse output scaling
    localparam logic [15:0] DUTY_INV     = 16'h7FFF;     // Signed position to inverse duty
    localparam logic [15:0] DUTY_FULL    = 16'hFFFF;     // Full-scale duty count
    localparam logic [5:0]  CLAMP_FULL   = 6'h3F;        // Largest clamp code
    localparam logic [15:0] CLAMP_STEP   = 16'h0208;     // Duty counts per clamp code

    // ==========================================================
    // Result word through the buffer: error, main, linear
    localparam int          RES_W        = 33;

    // Frame phases
    typedef enum logic [1:0] {F_IDLE, F_ADDR, F_DATA, F_DONE} ssphp_frame_t;

endpackage

// [inc/ssphp_pwm_if.sv]
// Carrier between frame engine and pulse generator
`timescale 1ns/100ps
interface ssphp_pwm_if;
    logic [15:0] position;                               // Signed linear position
    logic        err;                                    // Measurement error
    logic        enable;                                 // pulse_out_enable
    logic [2:0]  shift;                                  // pulse_resolution_shift
    logic [5:0]  upper_clamp;                            // duty_upper_clamp
    logic [5:0]  lower_clamp;                            // duty_lower_clamp

    modport src  (output position, err, enable, shift, upper_clamp, lower_clamp);
    modport sink (input  position, err, enable, shift, upper_clamp, lower_clamp);
endinterface

// [hw/ssphp_fifo.sv]
// Result buffer with valid and ready on both sides
`timescale 1ns/100ps
module ssphp_fifo #(
    parameter int W = 33,
    parameter int D = 16
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rstn,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem [D];                              // Storage words
    logic [AW-1:0] wr_ptr_reg;                           // Write pointer
    logic [AW-1:0] rd_ptr_reg;                           // Read pointer
    logic [CW-1:0] cnt_reg;                              // Words held
    logic          push;                                 // Accepted write
    logic          pop;                                  // Accepted read

    assign o_in_ready  = (cnt_reg != CW'(D));
    assign o_out_valid = (cnt_reg != '0);
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem[rd_ptr_reg];

    // Storage write
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
        end
    end
endmodule // ssphp_fifo

// [hw/ssphp_pwm.sv]
// Single-wire pulse output of the linear position
`timescale 1ns/100ps
module ssphp_pwm import ssphp_pkg::*; (
    input  wire logic  i_mclk,
    input  wire logic  i_rstn,
    ssphp_pwm_if.sink  pif,
    output logic       o_pwm
);
    logic [15:0] cnt_reg;                                // Period counter, one step per clock
    logic [15:0] duty_reg;                               // Duty held for one period
    logic [15:0] mask;                                   // Last count of the period
    logic [15:0] raw;                                    // Inverse duty, full scale
    logic [15:0] min_d;                                  // Floor from upper clamp code
    logic [15:0] max_d;                                  // Ceiling from lower clamp code
    logic [15:0] clamped;                                // Duty after clamping

    // Inverse linear map and clamping, then resolution shift
    always_comb begin
        mask    = DUTY_FULL >> pif.shift;
        raw     = pif.position ^ DUTY_INV;
        min_d   = 16'((CLAMP_FULL - pif.upper_clamp) * CLAMP_STEP);
        max_d   = DUTY_FULL - 16'(pif.lower_clamp * CLAMP_STEP);
        clamped = raw;
        if (raw < min_d) begin
            clamped = min_d;
        end else if (raw > max_d) begin
            clamped = max_d;
        end
    end

    // Period counter; duty sampled at period start to avoid runt pulses
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg  <= WORD_RST;
            duty_reg <= WORD_RST;
        end else begin
            cnt_reg <= (cnt_reg >= mask) ? WORD_RST : cnt_reg + 16'h0001;
            if (cnt_reg >= mask) begin
                duty_reg <= clamped >> pif.shift;
            end
        end
    end

    // Output stage; error or disable forces 0 percent
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pwm <= 1'b0;
        end else begin
            o_pwm <= pif.enable & ~pif.err &
                     ((duty_reg >= mask) | (cnt_reg < duty_reg));
        end
    end
endmodule // ssphp_pwm

// [hw/ssphp_top.sv]
// Serial frame engine with checksum, result buffer and pulse output
//
// Functional notes
// - Capture MOSI and drive MISO for rising SCK.
// - Frame is 16 address then 16 data bits.
// - Address top bit: 0 reads, 1 writes.
// - After address, shift addressed register out.
// - Reads return latest completed measurement.
// - Config write stores data, shifts old contents out.
// - After write, next frame echoes previous address.
// - Each read XORs content into checksum.
// - Checksum readable at its own address.
// - Pulse counts one system clock per step.
// - Shift position right 0 to 7 places.
// - Error forces zero percent duty.
// - Larger position gives smaller duty.
// - Enable bit 3, reset disabled.
// - Two 6-bit clamp fields bound duty.
// - Bits 2 to 0 hold resolution shift code.
// - Ready set on result, cleared by main or linear read.
// - Every serial register is 16 bits.
// - Duty linear in signed position value.
`timescale 1ns/100ps
module ssphp_top import ssphp_pkg::*; #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_sck,
    input  wire logic        i_cs_n,
    input  wire logic        i_mosi,
    output logic             o_miso,
    output logic             o_miso_oe_n,
    input  wire logic        i_meas_valid,
    output logic             o_meas_ready,
    input  wire logic [15:0] i_meas_main,
    input  wire logic [15:0] i_meas_lin,
    input  wire logic        i_meas_err,
    output logic             o_ready,
    output logic             o_pwm
);

    // ==========================================================
    // Declarations
    // Pin capture
    logic               sck_s1_reg;                      // SCK first sync stage
    logic               sck_s2_reg;                      // SCK second sync stage
    logic               sck_s3_reg;                      // SCK edge history
    logic               cs_s1_reg;                       // Select first sync stage
    logic               cs_s2_reg;                       // Select second sync stage
    logic               mosi_s1_reg;                     // MOSI first sync stage
    logic               mosi_s2_reg;                     // MOSI second sync stage
    logic               sck_rise;                        // Rising SCK seen
    logic               sck_fall;                        // Falling SCK seen
    logic               cs_act;                          // Frame in progress

    // Frame engine
    ssphp_frame_t       state_reg;                       // Frame phase
    logic [3:0]         bit_cnt_reg;                     // Bit within current half
    logic [15:0]        rx_reg;                          // MOSI shift register
    logic [15:0]        rx_next;                         // Shift register with new bit
    logic [15:0]        addr_reg;                        // Command word of the frame
    logic [15:0]        tx_reg;                          // MISO shift register
    logic [15:0]        prev_reg;                        // Word sent in next address half
    logic [15:0]        snap_reg;                        // Contents loaded for this frame
    logic [15:0]        rd_data;                         // Addressed register contents
    logic               load_evt;                        // Contents go onto MISO
    logic               last_rise;                       // Final data bit captured
    logic               is_write;                        // Frame is a write

    // Register file
    logic [15:0]        cfg_reg;                         // pwm_output_config
    logic [15:0]        chk_reg;                         // read_checksum
    logic [15:0]        main_reg;                        // Main output value
    logic [15:0]        lin_reg;                         // Linear position value
    logic               err_reg;                         // Error of last result
    logic               ready_set;                       // New result accepted
    logic               ready_clr;                       // Result register read

    // Buffer side
    logic               res_valid;                       // Buffer holds a result
    logic               res_take;                        // Buffer drain strobe
    logic [RES_W-1:0]   res_word;                        // Buffer head

    // Pulse side
    ssphp_pwm_if        pwm_bus ();                      // Carrier to pulse generator

    // ==========================================================
    // Input synchronisers
    // Two stages for every pin; edges found from stage two onward
    // Select resets high: no false frame
    // SCK resets low, its idle level
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sck_s1_reg  <= 1'b0;
            sck_s2_reg  <= 1'b0;
            sck_s3_reg  <= 1'b0;
            cs_s1_reg   <= 1'b1;
            cs_s2_reg   <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
        end else begin
            sck_s1_reg  <= i_sck;
            sck_s2_reg  <= sck_s1_reg;
            sck_s3_reg  <= sck_s2_reg;
            cs_s1_reg   <= i_cs_n;
            cs_s2_reg   <= cs_s1_reg;
            // Read only at detected rises
            mosi_s1_reg <= i_mosi;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    // Edge detection in the system clock domain
    // Masked while deselected
    // SCK half period must exceed 3 clocks
    assign cs_act   = ~cs_s2_reg;
    assign sck_rise = cs_act & sck_s2_reg & ~sck_s3_reg;
    assign sck_fall = cs_act & ~sck_s2_reg & sck_s3_reg;

    // ==========================================================
    // Frame decode helpers
    // Count is zero again in the data half
    assign rx_next   = {rx_reg[14:0], mosi_s2_reg};
    assign is_write  = addr_reg[DIR_BIT];
    assign load_evt  = sck_fall & (state_reg == F_DATA) & (bit_cnt_reg == 4'h0);
    assign last_rise = sck_rise & (state_reg == F_DATA) & (bit_cnt_reg == LAST_BIT);

    // Register read multiplexer, all words 16 bits
    // Decoded from the latched command
    always_comb begin
        unique case (addr_reg[14:0])
            ADDR_MAIN:    rd_data = main_reg;
            ADDR_LIN:     rd_data = lin_reg;
            ADDR_CHKSUM:  rd_data = chk_reg;
            ADDR_PWM_CFG: rd_data = cfg_reg;
            default:      rd_data = WORD_RST;            // Unmapped reads as zero
        endcase
    end

    // ==========================================================
    // Frame phase and bit counter
    // Count wraps 15 to 0 between halves
    // Only deselect leaves the done phase
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg   <= F_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (!cs_act) begin
            // Deselected: realign to address bit 15
            state_reg   <= F_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                F_IDLE: begin
                    // Spare clock before first rise
                    state_reg <= F_ADDR;
                end
                F_ADDR: begin
                    // Sixteen address bits
                    if (sck_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == LAST_BIT) begin
                            state_reg <= F_DATA;
                        end
                    end
                end
                F_DATA: begin
                    // Sixteen data bits
                    if (sck_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == LAST_BIT) begin
                            state_reg <= F_DONE;
                        end
                    end
                end
                F_DONE: begin
                    // Extra clocks ignored until deselect
                    state_reg <= F_DONE;
                end
            endcase
        end
    end

    // MOSI shift register
    // Free-running; latch points pick it up
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_reg <= WORD_RST;
        end else if (sck_rise) begin
            rx_reg <= rx_next;
        end
    end

    // Command word latched after the sixteenth address bit
    // Held until the next command
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_reg <= WORD_RST;
        end else if (sck_rise && state_reg == F_ADDR && bit_cnt_reg == LAST_BIT) begin
            addr_reg <= rx_next;
        end
    end

    // ==========================================================
    // MISO path
    // Preload while idle so the first bit is valid before the first rise
    // Fall shift gives half a period of setup
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_reg <= WORD_RST;
        end else if (!cs_act) begin
            // Deselected: hold the echo word
            tx_reg <= prev_reg;
        end else if (load_evt) begin
            tx_reg <= rd_data;
        end else if (sck_fall) begin
            // Next bit launched on falling SCK, sampled on rising
            tx_reg <= {tx_reg[14:0], 1'b0};
        end
    end

    // Contents captured for the word echo of the next frame
    // Old contents on write, data on read
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            snap_reg <= WORD_RST;
        end else if (load_evt) begin
            snap_reg <= rd_data;
        end
    end

    // Word for the next address half: address after write, data after read
    // A cut frame keeps the old word
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_reg <= WORD_RST;
        end else if (last_rise) begin
            prev_reg <= is_write ? addr_reg : snap_reg;
        end
    end

    // Pin drive: enable low only while selected
    // Two clocks behind the select pin
    assign o_miso      = tx_reg[15];
    assign o_miso_oe_n = cs_s2_reg;

    // ==========================================================
    // Configuration write
    // Committed only when all 16 data bits have arrived
    // Other write addresses are dropped
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_reg <= CFG_RST;
        end else if (last_rise && is_write && addr_reg[14:0] == ADDR_PWM_CFG) begin
            cfg_reg <= rx_next;
        end
    end

    // ==========================================================
    // Read checksum
    // Updated once per read frame, when the contents are loaded
    // Reading the checksum clears it
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            chk_reg <= CHK_RST;
        end else if (load_evt && !is_write) begin
            chk_reg <= chk_reg ^ rd_data;
        end
    end

    // ==========================================================
    // Result buffer
    // Drained only between frames so a frame sees stable contents
    // Fills while selected
    // One result per idle clock
    assign res_take = res_valid & ~cs_act;

    ssphp_fifo #(
        .W (RES_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rstn      (i_rstn),
        .i_in_valid  (i_meas_valid),
        .o_in_ready  (o_meas_ready),
        .i_in_data   ({i_meas_err, i_meas_main, i_meas_lin}),
        .o_out_valid (res_valid),
        .i_out_ready (~cs_act),
        .o_out_data  (res_word)
    );

    // Latest completed measurement
    // Error, main and linear move together
    // Held until the next drain
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            main_reg <= WORD_RST;
            lin_reg  <= WORD_RST;
            err_reg  <= 1'b0;
        end else if (res_take) begin
            err_reg  <= res_word[32];
            main_reg <= res_word[31:16];
            lin_reg  <= res_word[15:0];
        end
    end

    // ==========================================================
    // Ready flag
    // Set by a drain, cleared by a main or linear read
    assign ready_set = res_take;
    assign ready_clr = load_evt & ~is_write &
                       ((addr_reg[14:0] == ADDR_MAIN) | (addr_reg[14:0] == ADDR_LIN));

    // New result wins over a clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ready <= 1'b0;
        end else if (ready_set) begin
            o_ready <= 1'b1;
        end else if (ready_clr) begin
            o_ready <= 1'b0;
        end
    end

    // ==========================================================
    // Pulse output
    // Config fields to the generator
    assign pwm_bus.position    = lin_reg;
    assign pwm_bus.err         = err_reg;
    assign pwm_bus.enable      = cfg_reg[CFG_EN_BIT];
    assign pwm_bus.shift       = cfg_reg[CFG_SH_MSB:0];
    assign pwm_bus.upper_clamp = cfg_reg[CFG_HI_MSB:CFG_HI_LSB];
    assign pwm_bus.lower_clamp = cfg_reg[CFG_LO_MSB:CFG_LO_LSB];

    ssphp_pwm u_pwm (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .pif    (pwm_bus),
        .o_pwm  (o_pwm)
    );

endmodule // ssphp_top

// [tb/ssphp_chk.sv]
// Port-level assertion checker for the serial port block
`timescale 1ns/100ps
module ssphp_chk import ssphp_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic o_miso,
    input wire logic o_miso_oe_n,
    input wire logic i_meas_valid,
    input wire logic o_meas_ready,
    input wire logic o_ready,
    input wire logic o_pwm
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // ====
    // Frame tracker
    logic [5:0]  n_rise;                                 // Pin rises this frame
    logic [15:0] sh;                                     // Last 16 MOSI bits
    // Count rises while selected
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) n_rise <= 6'h00;
        else if (i_cs_n) n_rise <= 6'h00;
        else if ($rose(i_sck)) n_rise <= n_rise + 6'h01;
    end
    // Shift MOSI at each rise
    always_ff @(posedge i_mclk) begin
        if ($rose(i_sck)) sh <= {sh[14:0], i_mosi};
    end
    sequence s_idle; i_cs_n [*4]; endsequence
    sequence s_take; i_meas_valid && o_meas_ready; endsequence
    sequence s_hit; $rose(n_rise == 6'h10) && (sh == {1'b0, ADDR_LIN} || sh == {1'b0, ADDR_MAIN}); endsequence
    // ====
    // Assertions
    AST_OE_IDLE: assert property (s_idle |-> o_miso_oe_n)
        else $error("MISO driven while deselected");
    AST_OE_SEL: assert property (!i_cs_n [*4] |-> !o_miso_oe_n)
        else $error("MISO not driven while selected");
    AST_OE_SYNC: assert property (s_idle ##1 !i_cs_n |=> o_miso_oe_n)
        else $error("Select acted on before sync");
    AST_MISO_HOLD: assert property ($rose(i_sck) && !o_miso_oe_n |=> $stable(o_miso) [*3])
        else $error("MISO moved near rising clock");
    AST_RDY_SET: assert property (s_idle ##0 s_take ##1 i_cs_n [*2] |=> o_ready)
        else $error("Ready not set after result");
    AST_RDY_CLR: assert property (s_hit |-> ##[1:12] !o_ready)
        else $error("Ready not cleared by read");
    AST_RDY_HOLD: assert property (o_ready && i_cs_n |=> o_ready)
        else $error("Ready dropped while idle");
    AST_BUF_FREE: assert property (i_cs_n [*6] |-> o_meas_ready)
        else $error("Buffer stuck full while idle");
    AST_PWM_OFF: assert property ($rose(i_rstn) |-> !o_pwm [*8])
        else $error("Pulse output on after reset");
endmodule // ssphp_chk
bind ssphp_top ssphp_chk u_chk (.i_mclk, .i_rstn, .i_sck, .i_cs_n, .i_mosi, .o_miso, .o_miso_oe_n,
    .i_meas_valid, .o_meas_ready, .o_ready, .o_pwm);

// [tb/ssphp_spi_master.sv]
// Serial master model that runs whole frames
`timescale 1ns/100ps
module ssphp_spi_master (
    input  wire logic i_mclk,
    input  wire logic i_miso,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // One frame of 32 bits, MSB first, clock idle low
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        o_cs_n <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_mosi <= w[i];
            repeat (4) @(posedge i_mclk);
            o_sck <= 1'b1;
            r[i] = i_miso;
            repeat (4) @(posedge i_mclk);
            o_sck <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi; // Released line shows inverse
        repeat (6) @(posedge i_mclk);
    endtask
endmodule // ssphp_spi_master

// [tb/ssphp_tb_top.sv]
// Top testbench for the serial port block
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, a); end end
module ssphp_tb_top import ssphp_pkg::*; ;
    logic        i_mclk = 1'b0, i_rstn = 1'b0, i_sck, i_cs_n, i_mosi, i_meas_valid = 1'b0, i_meas_err = 1'b0;
    logic [15:0] i_meas_main = 16'h0000, i_meas_lin = 16'h0000, pw = 16'h0000, ck = CHK_RST, cf = CFG_RST;
    logic        o_miso, o_miso_oe_n, o_meas_ready, o_ready, o_pwm;
    int          error_cnt = 0, n_checks = 0, cyc = 0, hi, acc;
    always #50 i_mclk = ~i_mclk;
    ssphp_top #(.FIFO_DEPTH(16)) dut (.i_mclk, .i_rstn, .i_sck, .i_cs_n, .i_mosi, .o_miso, .o_miso_oe_n,
        .i_meas_valid, .o_meas_ready, .i_meas_main, .i_meas_lin, .i_meas_err, .o_ready, .o_pwm);
    ssphp_spi_master u_m (.i_mclk, .i_miso(o_miso), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_mosi(i_mosi));
    task automatic report_and_stop;
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge i_mclk) if (++cyc == 40000) begin
        error_cnt++;
        report_and_stop;
    end
    // One frame; tracks echoed word and checksum
    task automatic frame(input logic [15:0] a, input logic [15:0] wd, input logic [15:0] ed);
        logic [31:0] r;
        u_m.xfer({a, wd}, r);
        `CHK("prev_word", pw, r[31:16])
        `CHK("reg_data", ed, r[15:0])
        pw = a[15] ? a : ed;
        if (!a[15]) ck ^= ed;
    endtask
    // Offer one result and wait for it to be taken
    task automatic push(input logic [15:0] l, input logic e);
        i_meas_valid <= 1'b1;
        i_meas_lin <= l;
        i_meas_main <= ~l;
        i_meas_err <= e;
        @(posedge i_mclk);
        while (o_meas_ready !== 1'b1) @(posedge i_mclk);
        i_meas_valid <= 1'b0;
        @(posedge i_mclk);
    endtask
    // Pulse duty over a 1024-cycle window per setting
    task automatic t_pwm_table;
        logic [15:0] c [8] = '{16'hFC0F, 16'hFC0F, 16'hFC0F, 16'hFC0F,
                               16'h000F, 16'hFC07, 16'hFFFF, 16'hFC0E};
        logic [15:0] l [8] = '{16'h0000, 16'h4000, 16'h8000, 16'h0000,
                               16'h4000, 16'h0000, 16'h8000, 16'h0000};
        logic [7:0]  e = 8'h08;
        int          x [8] = '{510, 254, 1024, 0, 510, 0, 512, 511};
        for (int i = 0; i < 8; i++) begin
            frame(16'h800D, c[i], cf);
            cf = c[i];
            push(l[i], e[i]);
            repeat (1100) @(posedge i_mclk);
            hi = 0;
            repeat (1024) begin
                @(posedge i_mclk);
                hi += (o_pwm === 1'b1);
            end
            `CHK("pwm_high", x[i], hi)
        end
    endtask
    // Ready flag, read side effects, checksum
    task automatic t_ready;
        `CHK("ready_set", 1'b1, o_ready)
        frame(16'h0122, 16'h0000, 16'h0000);
        `CHK("ready_clr", 1'b0, o_ready)
        frame(16'h0100, 16'h0000, 16'hFFFF);
        frame(16'h000D, 16'h0000, cf);
        frame(16'h0055, 16'h0000, 16'h0000);
        repeat (2) frame(16'h0108, 16'h0000, ck);
    endtask
    // Fill the buffer during a frame, then read the newest result
    task automatic t_fill;
        acc = 0;
        fork
            frame(16'h0055, 16'h0000, 16'h0000);
            begin
                repeat (10) @(posedge i_mclk);
                repeat (20) begin
                    i_meas_valid <= 1'b1;
                    i_meas_lin <= 16'h0100 + acc[15:0];
                    @(posedge i_mclk);
                    if (o_meas_ready === 1'b1) acc++;
                end
                i_meas_valid <= 1'b0;
            end
        join
        `CHK("fifo_taken", 16, acc)
        repeat (30) @(posedge i_mclk);
        frame(16'h0122, 16'h0000, 16'h010F);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        t_pwm_table;
        t_ready;
        t_fill;
        report_and_stop;
    end
endmodule // ssphp_tb_top
